// File: design/pfc_ctrl_regs.sv
`timescale 1ns/1ps
// Operation
// - Far-end fault enable bit, reset zero
// - Fiber mode is register bit OR pin
// - Test bit sends 10 MHz ones when powered
// - Keep bit holds 10M logic powered while link is up
// - Jabber disable bit switches jabber off
// - Enhanced link integrity is bit OR pin
// - Heartbeat enable effective only at 10M
// - Long line bit selects lower squelch threshold
// - Autopolarity detection runs at 10M when disable clear
// - Detected reversal sets status and corrects
// - Disable bit leaves reversal uncorrected
// - Serial select ignored at 100M
// - No link pulse ignored at 100M
// - Polarity status read-only, shows corrected reversal
module pfc_ctrl_regs
    import pfc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    input  wire logic [4:0]  mgmt_addr,
    input  wire logic        mgmt_wr,
    input  wire logic        mgmt_rd,
    input  wire logic [15:0] mgmt_wdata,
    output logic      [15:0] mgmt_rdata_q,
    input  wire logic        fiber_mode_pin,
    input  wire logic        enhanced_link_integrity_pin,
    input  wire logic        speed_100,
    input  wire logic        ten_powered,
    input  wire logic        link_up,
    input  wire logic        rx_active,
    input  wire logic        polarity_reversed,
    output logic             far_end_fault_en_q,
    output logic             fiber_mode_q,
    output logic             ten_test_tone_q,
    output logic             ten_rx_full_power_q,
    output logic             jabber_en_q,
    output logic             enhanced_link_integrity_q,
    output logic             heartbeat_en_q,
    output logic             low_squelch_q,
    output logic             polarity_detect_en_q,
    output logic             polarity_correct_q,
    output logic             polarity_fix_status_q,
    output logic             serial_mode_q,
    output logic             no_link_pulse_q
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Bits that only mean something in 10 Mbit/s operation
    function automatic logic ten_only(input logic bit_val,
                                      input logic is_ten);
        return bit_val & is_ten;
    endfunction

    // Stored bit combined with its pin; the stored value is left alone
    function automatic logic with_pin(input logic bit_val,
                                      input logic pin_val);
        return bit_val | pin_val;
    endfunction

    // Register number match
    function automatic logic addr_hit(input logic [4:0] addr,
                                      input logic [4:0] reg_addr);
        return addr == reg_addr;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic fiber_pin_s;
    logic eli_pin_s;

    pfc_sync u_sync_fiber (
        .ref_clk  (ref_clk),
        .arst_n   (arst_n),
        .pin_in   (fiber_mode_pin),
        .pin_sync (fiber_pin_s)
    );

    pfc_sync u_sync_eli (
        .ref_clk  (ref_clk),
        .arst_n   (arst_n),
        .pin_in   (enhanced_link_integrity_pin),
        .pin_sync (eli_pin_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register file

    logic [15:0] hundred_q;
    logic [15:0] ten_q;
    logic [15:0] hundred_d;
    logic [15:0] ten_d;
    logic [15:0] rdata_d;
    logic        sel_hundred;
    logic        sel_ten;

    assign sel_hundred = addr_hit(mgmt_addr, HUNDRED_MBIT_CONTROL_ADDR);
    assign sel_ten     = addr_hit(mgmt_addr, TEN_MBIT_CONTROL_ADDR);

    // Upper bits of the 100M register are outside this block and read zero
    assign hundred_d = (mgmt_wr && sel_hundred)
                     ? (mgmt_wdata & HUNDRED_IMPL_MASK) : hundred_q;
    // Reserved bits are stored as written
    assign ten_d     = (mgmt_wr && sel_ten) ? mgmt_wdata : ten_q;

    assign rdata_d = sel_hundred ? hundred_q :
                     sel_ten     ? ten_q     : RDATA_RESET;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            hundred_q <= HUNDRED_RESET;
        end else begin
            hundred_q <= hundred_d;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ten_q <= TEN_RESET;
        end else begin
            ten_q <= ten_d;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            mgmt_rdata_q <= RDATA_RESET;
        end else if (mgmt_rd) begin
            mgmt_rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Effective controls

    logic ten_mode;
    logic fault_en_d;
    logic fiber_d;
    logic tone_d;
    logic full_pwr_d;
    logic jab_d;
    logic eli_d;
    logic hb_d;
    logic sq_d;
    logic pol_det_d;
    logic pol_cor_d;
    logic serial_d;
    logic nlp_d;

    assign ten_mode   = !speed_100;
    assign fault_en_d = hundred_q[FAR_END_FAULT_ENABLE_BIT];
    assign fiber_d    = with_pin(hundred_q[FIBER_MODE_BIT_POS],
                                 fiber_pin_s);
    assign tone_d     = ten_q[TEN_TEST_TONE_BIT] & ten_powered;
    // Full power only while link is up, and then only with the keep bit set or while receiving
    assign full_pwr_d = link_up
                      & (ten_q[RX_KEEP_POWERED_BIT] | rx_active);
    assign jab_d      = !ten_q[JABBER_DISABLE_BIT];
    assign eli_d      = with_pin(ten_q[ENHANCED_LINK_BIT],
                                 eli_pin_s);
    assign hb_d       = ten_only(ten_q[HEARTBEAT_ENABLE_BIT],
                                 ten_mode);
    assign sq_d       = ten_only(ten_q[LONG_LINE_ENABLE_BIT],
                                 ten_mode);
    assign pol_det_d  = ten_only(!ten_q[POLARITY_FIX_DISABLE_BIT],
                                 ten_mode);
    assign pol_cor_d  = pol_det_d & polarity_reversed;
    assign serial_d   = ten_only(ten_q[SERIAL_SELECT_BIT],
                                 ten_mode);
    assign nlp_d      = ten_only(ten_q[NO_LINK_PULSE_BIT],
                                 ten_mode);

    // Settings of the 100 Mbit/s side
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            far_end_fault_en_q <= 1'b0;
            fiber_mode_q       <= 1'b0;
        end else begin
            far_end_fault_en_q <= fault_en_d;
            fiber_mode_q       <= fiber_d;
        end
    end

    // Power, test, jabber and link integrity controls of the 10 Mbit/s side
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ten_test_tone_q           <= 1'b0;
            ten_rx_full_power_q       <= 1'b0;
            jabber_en_q               <= 1'b1;
            enhanced_link_integrity_q <= 1'b0;
        end else begin
            ten_test_tone_q           <= tone_d;
            ten_rx_full_power_q       <= full_pwr_d;
            jabber_en_q               <= jab_d;
            enhanced_link_integrity_q <= eli_d;
        end
    end

    // Line options valid at 10 Mbit/s only
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            heartbeat_en_q  <= 1'b0;
            low_squelch_q   <= 1'b0;
            serial_mode_q   <= 1'b0;
            no_link_pulse_q <= 1'b0;
        end else begin
            heartbeat_en_q  <= hb_d;
            low_squelch_q   <= sq_d;
            serial_mode_q   <= serial_d;
            no_link_pulse_q <= nlp_d;
        end
    end

    // Polarity detection, correction and its status
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            polarity_detect_en_q  <= 1'b0;
            polarity_correct_q    <= 1'b0;
            polarity_fix_status_q <= 1'b0;
        end else begin
            polarity_detect_en_q  <= pol_det_d;
            polarity_correct_q    <= pol_cor_d;
            polarity_fix_status_q <= pol_cor_d;
        end
    end

endmodule

// File: design/pfc_sync.sv
`timescale 1ns/1ps
module pfc_sync
    import pfc_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic arst_n,
    input  wire logic pin_in,
    output logic      pin_sync
);

    logic [SYNC_STAGES-1:0] stage_q;

    // Only the last stage is read outside
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            stage_q <= '0;
        end else begin
            stage_q <= {stage_q[SYNC_STAGES-2:0], pin_in};
        end
    end

    assign pin_sync = stage_q[SYNC_STAGES-1];

endmodule

// File: pkg/pfc_pkg.sv
package pfc_pkg;

    // Management register numbers
    localparam logic [4:0]  HUNDRED_MBIT_CONTROL_ADDR = 5'h1D;
    localparam logic [4:0]  TEN_MBIT_CONTROL_ADDR     = 5'h1E;

    // Field positions, 100 Mbit/s control
    localparam int          FAR_END_FAULT_ENABLE_BIT  = 1;
    localparam int          FIBER_MODE_BIT_POS        = 0;

    // Field positions, 10 Mbit/s control
    localparam int          TEN_TEST_TONE_BIT         = 15;
    localparam int          RX_KEEP_POWERED_BIT       = 14;
    localparam int          JABBER_DISABLE_BIT        = 13;
    localparam int          ENHANCED_LINK_BIT         = 6;
    localparam int          HEARTBEAT_ENABLE_BIT      = 5;
    localparam int          LONG_LINE_ENABLE_BIT      = 4;
    localparam int          POLARITY_FIX_DISABLE_BIT  = 3;
    localparam int          SERIAL_SELECT_BIT         = 1;
    localparam int          NO_LINK_PULSE_BIT         = 0;

    // Implemented bits of the 100 Mbit/s control register
    localparam logic [15:0] HUNDRED_IMPL_MASK         = 16'h0003;

    // Reset values
    localparam logic [15:0] HUNDRED_RESET             = 16'h0000;
    localparam logic [15:0] TEN_RESET                 = 16'h0000;
    localparam logic [15:0] RDATA_RESET               = 16'h0000;

    // Synchroniser depth for pins
    localparam int          SYNC_STAGES               = 2;

endpackage

// File: testbench/pfc_ctrl_regs_properties.sv
`timescale 1ns/1ps
module pfc_ctrl_regs_properties import pfc_pkg::*; (
    input wire logic        ref_clk,
    input wire logic        arst_n,
    input wire logic [4:0]  mgmt_addr,
    input wire logic        mgmt_wr,
    input wire logic [15:0] mgmt_wdata,
    input wire logic        fiber_mode_pin,
    input wire logic        speed_100,
    input wire logic        ten_powered,
    input wire logic        polarity_reversed,
    input wire logic        far_end_fault_en_q,
    input wire logic        fiber_mode_q,
    input wire logic        ten_test_tone_q,
    input wire logic        jabber_en_q,
    input wire logic        heartbeat_en_q,
    input wire logic        low_squelch_q,
    input wire logic        polarity_detect_en_q,
    input wire logic        polarity_correct_q,
    input wire logic        polarity_fix_status_q,
    input wire logic        serial_mode_q,
    input wire logic        no_link_pulse_q
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    wire hit_h = mgmt_addr == HUNDRED_MBIT_CONTROL_ADDR;
    wire hit_t = mgmt_addr == TEN_MBIT_CONTROL_ADDR;
    a_fault_en_write: assert property (mgmt_wr && hit_h ##1 !mgmt_wr |=>
        far_end_fault_en_q == $past(mgmt_wdata[1], 2)) else $error("fault");
    a_jabber_write: assert property (mgmt_wr && hit_t ##1 !mgmt_wr |=>
        jabber_en_q == !$past(mgmt_wdata[13], 2)) else $error("jabber");
    a_ten_only_bits: assert property (speed_100 |=>
        !(heartbeat_en_q || low_squelch_q || serial_mode_q ||
        no_link_pulse_q || polarity_detect_en_q)) else $error("speed");
    a_status_tracks: assert property (
        polarity_fix_status_q == polarity_correct_q) else $error("status");
    a_status_source: assert property (
        polarity_fix_status_q |-> $past(polarity_reversed) &&
        !$past(speed_100)) else $error("status source");
    a_fix_needs_detect: assert property (
        polarity_correct_q |-> polarity_detect_en_q) else $error("fix");
    a_fix_needs_flip: assert property (
        !polarity_reversed |=> !polarity_correct_q) else $error("flip");
    a_tone_power: assert property (
        !ten_powered |=> !ten_test_tone_q) else $error("tone");
    a_fiber_pin: assert property (
        fiber_mode_pin [*3] |=> fiber_mode_q) else $error("fiber");
    cover property (mgmt_wr && hit_t);
    cover property (polarity_correct_q);
    cover property (fiber_mode_q);
endmodule

bind pfc_ctrl_regs pfc_ctrl_regs_properties i_pfc_ctrl_regs_properties (.*);

// File: testbench/test_phy_fiber_and_tenbase_control_regs.sv
`timescale 1ns/1ps
module test_phy_fiber_and_tenbase_control_regs import pfc_pkg::*; ;
    logic        ref_clk = 1'b0, arst_n = 1'b0, mgmt_wr = 1'b0;
    logic        mgmt_rd = 1'b0, speed_100 = 1'b0, ten_powered = 1'b1;
    logic        link_up = 1'b1, rx_active = 1'b0, polarity_reversed = 1'b0;
    logic        fiber_mode_pin = 1'b0, enhanced_link_integrity_pin = 1'b0;
    logic [4:0]  mgmt_addr = 5'h00;
    logic [15:0] mgmt_wdata = 16'h0000, mgmt_rdata_q;
    logic        far_end_fault_en_q, fiber_mode_q, ten_test_tone_q;
    logic        ten_rx_full_power_q, jabber_en_q, enhanced_link_integrity_q;
    logic        heartbeat_en_q, low_squelch_q, polarity_detect_en_q;
    logic        polarity_correct_q, polarity_fix_status_q, serial_mode_q;
    logic        no_link_pulse_q;
    int          num_errors = 0, n_compared = 0;
    wire  [15:0] outs = {3'h0, far_end_fault_en_q, fiber_mode_q,
        ten_test_tone_q, ten_rx_full_power_q, jabber_en_q,
        enhanced_link_integrity_q, heartbeat_en_q, low_squelch_q,
        polarity_detect_en_q, polarity_correct_q, polarity_fix_status_q,
        serial_mode_q, no_link_pulse_q};
    pfc_ctrl_regs i_pfc_ctrl_regs (.*);
    always #20 ref_clk = ~ref_clk;
    task automatic conclude;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        mgmt_addr = a;
        mgmt_wdata = d;
        mgmt_wr = 1'b1;
        @(negedge ref_clk) mgmt_wr = 1'b0;
        repeat (2) @(negedge ref_clk);
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        mgmt_addr = a;
        mgmt_rd = 1'b1;
        @(negedge ref_clk) mgmt_rd = 1'b0;
        chk(mgmt_rdata_q, exp);
        @(negedge ref_clk);
    endtask
    initial begin
        repeat (2) @(negedge ref_clk);
        arst_n = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk(outs, 16'h0110);
        wr(5'h1E, 16'hE07B);
        chk(outs, 16'h06E3);
        rd(5'h1E, 16'hE07B);
        speed_100 = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk(outs, 16'h0680);
        {speed_100, ten_powered, polarity_reversed} = 3'b001;
        wr(5'h1E, 16'h0008);
        chk(outs, 16'h0100);
        rx_active = 1'b1;
        wr(5'h1E, 16'h0000);
        chk(outs, 16'h031C);
        polarity_reversed = 1'b0;
        wr(5'h1D, 16'hFFFF);
        chk(outs, 16'h1B10);
        rd(5'h1D, 16'h0003);
        wr(5'h1F, 16'hFFFF);
        rd(5'h1F, 16'h0000);
        wr(5'h1D, 16'h0000);
        {fiber_mode_pin, enhanced_link_integrity_pin} = 2'b11;
        repeat (4) @(negedge ref_clk);
        chk(outs, 16'h0B90);
        rd(5'h1D, 16'h0000);
        rd(5'h1E, 16'h0000);
        conclude;
    end
endmodule
